// ===== pkg/pcstk_pkg.sv
// Purpose: constants and types for the program counter and return stack
// Assumes: one instruction clock, decoder supplies a 3-bit encoded op
// Notes:   widths follow the 13-bit program counter
`default_nettype none
package pcstk_pkg;
    localparam int unsigned PC_W        = 13;
    localparam int unsigned LOW_W       = 8;
    localparam int unsigned HIGH_W      = 5;
    localparam int unsigned IMM_W       = 11;
    localparam int unsigned STK_DEPTH   = 8;
    localparam int unsigned STK_PTR_W   = 3;
    localparam logic [12:0] PC_RST      = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR  = 13'h0004;
    localparam logic [2:0]  PTR_RST     = 3'h0;
    localparam int unsigned LATCH_TOP_LO = 3; // latch bits 4:3 feed pc bits 12:11

    // operation selected by the decoder for this instruction cycle
    typedef enum logic [2:0] {
        PCSTK_OP_STEP  = 3'h0, // plain advance
        PCSTK_OP_JUMP  = 3'h1, // jump to immediate
        PCSTK_OP_CALL  = 3'h3, // call: push then jump
        PCSTK_OP_RET   = 3'h2, // return / literal / from interrupt
        PCSTK_OP_IRQ   = 3'h6, // interrupt vectoring: push then vector
        PCSTK_OP_WRLOW = 3'h7, // instruction writes pc_low_byte_reg
        PCSTK_OP_HOLD  = 3'h5  // stall, keep pc
    } pcstk_op_t;

    typedef struct packed {
        pcstk_op_t         op;
        logic [IMM_W-1:0]  imm;        // immediate address field
        logic [LOW_W-1:0]  low_wdata;  // value written to pc_low_byte_reg
        logic [HIGH_W-1:0] pc_high_latch;
    } pcstk_ctl_t;
endpackage : pcstk_pkg
`default_nettype wire

// ===== verilog/pcstk_core.sv
// Purpose: 13-bit program counter with eight-deep circular return stack
// Assumes: one control word per cycle from the decoder; latch held outside
// Notes:   stack pointer never leaves this module
`default_nettype none
module pcstk_core
    import pcstk_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire pcstk_ctl_t  i_ctl,
    output logic [PC_W-1:0]  o_pc,
    output logic [LOW_W-1:0] o_pc_low_byte_reg
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [PC_W-1:0]      pc_r;
    logic [PC_W-1:0]      pc_nxt;
    logic [PC_W-1:0]      stk_r [STK_DEPTH];
    logic [STK_PTR_W-1:0] ptr_r;
    logic [STK_PTR_W-1:0] ptr_nxt;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] v);
        pc_inc = PC_W'(v + 1'b1);
    endfunction

    // ops that save a return address
    function automatic logic op_pushes(input pcstk_op_t op);
        op_pushes = (op == PCSTK_OP_CALL) || (op == PCSTK_OP_IRQ);
    endfunction

    // ops that take a return address back
    function automatic logic op_pops(input pcstk_op_t op);
        op_pops = (op == PCSTK_OP_RET);
    endfunction

    // push on call and interrupt, pop on any return
    wire logic do_push = op_pushes(i_ctl.op);
    wire logic do_pop  = op_pops(i_ctl.op);
    wire logic [STK_PTR_W-1:0] ptr_dec = STK_PTR_W'(ptr_r - 1'b1);
    // upper two from latch, rest from immediate
    wire logic [PC_W-1:0] jump_tgt =
        {i_ctl.pc_high_latch[HIGH_W-1:LATCH_TOP_LO], i_ctl.imm};
    // all thirteen bits change together on a low-byte write
    // latch is only read here and above, never written back
    wire logic [PC_W-1:0] wrlow_tgt = {i_ctl.pc_high_latch, i_ctl.low_wdata};

    // next pc selection
    always_comb
    begin
        case (i_ctl.op)
            PCSTK_OP_STEP:  pc_nxt = pc_inc(pc_r);
            PCSTK_OP_JUMP:  pc_nxt = jump_tgt;
            PCSTK_OP_CALL:  pc_nxt = jump_tgt;
            PCSTK_OP_RET:   pc_nxt = stk_r[ptr_dec];
            PCSTK_OP_IRQ:   pc_nxt = IRQ_VECTOR;
            PCSTK_OP_WRLOW: pc_nxt = wrlow_tgt;
            PCSTK_OP_HOLD:  pc_nxt = pc_r;
            default:        pc_nxt = pc_inc(pc_r);
        endcase
    end

    // pointer wraps silently in both directions, no status out
    assign ptr_nxt = do_push ? STK_PTR_W'(ptr_r + 1'b1) :
                     do_pop  ? ptr_dec : ptr_r;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // program counter and hidden pointer
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            pc_r  <= PC_RST;
            ptr_r <= PTR_RST;
        end
        else
        begin
            pc_r  <= pc_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    // stack storage; call pushes next address, interrupt pushes current address, oldest overwritten
    always_ff @(posedge i_ref_clk)
    begin
        if (do_push)
        begin
            stk_r[ptr_r] <= (i_ctl.op == PCSTK_OP_IRQ) ? pc_r : pc_inc(pc_r);
        end
    end

    assign o_pc              = pc_r;
    assign o_pc_low_byte_reg = pc_r[LOW_W-1:0];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence call_seq;
        i_ctl.op == PCSTK_OP_CALL;
    endsequence
    sequence ret_seq;
        i_ctl.op == PCSTK_OP_RET;
    endsequence

    // interrupt vectoring
    sequence irq_seq;
        i_ctl.op == PCSTK_OP_IRQ;
    endsequence
    // plain jump
    sequence jump_seq;
        i_ctl.op == PCSTK_OP_JUMP;
    endsequence
    // stall
    sequence hold_seq;
        i_ctl.op == PCSTK_OP_HOLD;
    endsequence
    // low byte written
    sequence wrlow_seq;
        i_ctl.op == PCSTK_OP_WRLOW;
    endsequence
    // plain advance
    sequence step_seq;
        i_ctl.op == PCSTK_OP_STEP;
    endsequence
    // two nested calls unwound by two returns
    sequence nest_seq;
        call_seq ##1 call_seq ##1 ret_seq ##1 ret_seq;
    endsequence
    // eight pushes in a row walk the whole ring
    sequence ring_seq;
        do_push [*8];
    endsequence

    // ----------------------------------------------------------------
    // program counter checks
    // ----------------------------------------------------------------
    // reset forces the counter to zero
    pc_reset_a: assert property (
        disable iff (1'b0)
        !i_rst_n |=> o_pc == PC_RST)
        else $error("pc not cleared by reset");

    // reset also rewinds the hidden pointer
    ptr_reset_a: assert property (
        disable iff (1'b0)
        !i_rst_n |=> ptr_r == PTR_RST)
        else $error("pointer not cleared by reset");

    // plain advance by one word
    pc_step_a: assert property (
        step_seq
        |=> o_pc == PC_W'($past(o_pc) + 1'b1))
        else $error("pc did not advance");

    // unused op code behaves as advance
    odd_op_a: assert property (
        i_ctl.op == pcstk_op_t'(3'h4)
        |=> o_pc == PC_W'($past(o_pc) + 1'b1))
        else $error("unknown op did not advance");

    // top of range wraps to zero
    step_wrap_a: assert property (
        i_ctl.op == PCSTK_OP_STEP && o_pc == {PC_W{1'b1}}
        |=> o_pc == PC_RST)
        else $error("pc did not wrap");

    // stall keeps the counter
    hold_keep_a: assert property (
        hold_seq
        |=> $stable(o_pc))
        else $error("pc moved on hold");

    // upper bits untouched while the low byte does not carry
    upper_keep_a: assert property (
        i_ctl.op == PCSTK_OP_STEP && o_pc[LOW_W-1:0] != 8'hff
        |=> $stable(o_pc[PC_W-1:LOW_W]))
        else $error("upper bits changed");

    // low write loads all thirteen bits at once
    wrlow_load_a: assert property (
        wrlow_seq
        |=> o_pc == {$past(i_ctl.pc_high_latch), $past(i_ctl.low_wdata)})
        else $error("low write load wrong");

    // written low byte reads back
    wrlow_low_a: assert property (
        wrlow_seq
        |=> o_pc_low_byte_reg == $past(i_ctl.low_wdata))
        else $error("low byte write lost");

    // low byte output mirrors the counter
    low_out_a: assert property (
        1'b1
        |-> o_pc_low_byte_reg == o_pc[LOW_W-1:0])
        else $error("low byte mismatch");

    // jump target from latch top and immediate
    jump_load_a: assert property (
        jump_seq
        |=> o_pc == {$past(i_ctl.pc_high_latch[4:3]), $past(i_ctl.imm)})
        else $error("jump target wrong");

    // call target built the same way
    call_load_a: assert property (
        call_seq
        |=> o_pc == {$past(i_ctl.pc_high_latch[4:3]), $past(i_ctl.imm)})
        else $error("call target wrong");

    // interrupt lands on the vector
    irq_vec_a: assert property (
        irq_seq
        |=> o_pc == IRQ_VECTOR)
        else $error("interrupt vector wrong");

    // ----------------------------------------------------------------
    // stack checks
    // ----------------------------------------------------------------
    // call saves the following address
    call_push_a: assert property (
        call_seq
        |=> stk_r[$past(ptr_r)] == PC_W'($past(o_pc) + 1'b1))
        else $error("call push wrong");

    // interrupt saves the current address
    irq_push_a: assert property (
        irq_seq
        |=> stk_r[$past(ptr_r)] == $past(o_pc))
        else $error("interrupt push wrong");

    // return after a call resumes behind it
    call_ret_a: assert property (
        call_seq ##1 ret_seq
        |=> o_pc == PC_W'($past(o_pc, 2) + 1'b1))
        else $error("return address wrong");

    // return after an interrupt resumes where it was
    irq_ret_a: assert property (
        irq_seq ##1 ret_seq
        |=> o_pc == $past(o_pc, 2))
        else $error("interrupt return wrong");

    // nested returns unwind in order
    nest_ret_a: assert property (
        nest_seq
        |=> o_pc == PC_W'($past(o_pc, 4) + 1'b1))
        else $error("nested return wrong");

    // push advances the pointer modulo depth
    ptr_wrap_a: assert property (
        do_push
        |=> ptr_r == STK_PTR_W'($past(ptr_r) + 1'b1))
        else $error("pointer not circular");

    // pop steps back silently
    pop_ptr_a: assert property (
        do_pop
        |=> ptr_r == STK_PTR_W'($past(ptr_r) - 1'b1))
        else $error("pop pointer wrong");

    // other ops leave the pointer alone
    ptr_keep_a: assert property (
        !do_push && !do_pop
        |=> $stable(ptr_r))
        else $error("pointer moved");

    // eight pushes bring the pointer round
    ring_lap_a: assert property (
        ring_seq
        |=> ptr_r == $past(ptr_r, 8))
        else $error("ring lap wrong");

    // ninth push lands in the first slot
    ring_slot_a: assert property (
        ring_seq ##1 do_push
        |-> ptr_r == $past(ptr_r, 8))
        else $error("ninth push slot wrong");

    // pop leaves the entry in place
    pop_keeps_a: assert property (
        ret_seq
        |=> stk_r[$past(ptr_dec)] == $past(stk_r[ptr_dec]))
        else $error("pop disturbed entry");
endmodule // pcstk_core
`default_nettype wire

// ===== test/pcstk_dec_model.sv
// Purpose: decoder side model, packs one control word per cycle
// Assumes: bench sets the fields at the falling edge
// Notes:   the latch lives here and push or pop never touches it
`default_nettype none
module pcstk_dec_model
    import pcstk_pkg::*;
(
    input  wire pcstk_op_t         i_op,
    input  wire logic [IMM_W-1:0]  i_imm,
    input  wire logic [LOW_W-1:0]  i_wd,
    input  wire logic [HIGH_W-1:0] i_latch,
    output wire pcstk_ctl_t        o_ctl
);
    // latch passes through untouched by stack traffic
    assign o_ctl = {i_op, i_imm, i_wd, i_latch};
endmodule // pcstk_dec_model
`default_nettype wire

// ===== test/pcstk_core_tb.sv
// Purpose: self-checking bench for pcstk_core
// Assumes: 25 MHz clock, synchronous active-low reset
// Notes:   inputs change at the falling edge
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module pcstk_core_tb
    import pcstk_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    pcstk_op_t         op = PCSTK_OP_HOLD;
    logic [IMM_W-1:0]  imm = '0;
    logic [LOW_W-1:0]  wd = '0;
    logic [HIGH_W-1:0] latch = '0;
    pcstk_ctl_t        ctl;
    logic [PC_W-1:0]   pc;
    logic [LOW_W-1:0]  pc_low_byte_reg;
    int                mismatches = 0;
    int                cmp_count = 0;
    int                cyc = 0;
    always #20 clk = ~clk;
    pcstk_dec_model dec_u (.i_op(op), .i_imm(imm), .i_wd(wd), .i_latch(latch), .o_ctl(ctl));
    pcstk_core dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ctl(ctl), .o_pc(pc),
        .o_pc_low_byte_reg(pc_low_byte_reg));
    // one instruction cycle
    task automatic go(input pcstk_op_t o, input logic [10:0] i, input logic [7:0] w,
                      input logic [HIGH_W-1:0] l = '0);
        @(negedge clk);
        op = o;
        imm = i;
        wd = w;
        latch = l;
        @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic t_basic();
        `CHK("pc rst", 13'h0000, pc)
        go(PCSTK_OP_STEP, 11'h000, 8'h00);
        `CHK("pc step", 13'h0001, pc)
        go(PCSTK_OP_HOLD, 11'h000, 8'h00);
        `CHK("pc hold", 13'h0001, pc)
        go(pcstk_op_t'(3'h4), 11'h000, 8'h00);
        `CHK("pc odd op", 13'h0002, pc)
    endtask
    task automatic t_wrlow();
        go(PCSTK_OP_WRLOW, 11'h000, 8'hff, 5'h15);
        `CHK("pc wrlow", 13'h15ff, pc)
        `CHK("low byte", 8'hff, pc_low_byte_reg)
        go(PCSTK_OP_STEP, 11'h000, 8'h00);
        `CHK("pc carry", 13'h1600, pc)
        go(PCSTK_OP_WRLOW, 11'h000, 8'h02, 5'h16);
        `CHK("pc table", 13'h1602, pc)
    endtask
    task automatic t_jump();
        go(PCSTK_OP_JUMP, 11'h7ff, 8'h00, 5'h1b);
        `CHK("pc jump", 13'h1fff, pc)
        go(PCSTK_OP_STEP, 11'h000, 8'h00);
        `CHK("pc wrap", 13'h0000, pc)
    endtask
    task automatic t_stack();
        for (int k = 0; k < 9; k++)
        begin
            go(PCSTK_OP_CALL, 11'(k * 8), 8'h00);
            `CHK("pc call", 13'(k * 8), pc)
        end
        for (int i = 1; i < 10; i++)
        begin
            go(PCSTK_OP_RET, 11'h000, 8'h00);
            `CHK("pc ret", 13'(i < 9 ? (8 - i) * 8 + 1 : 57), pc)
        end
    endtask
    task automatic t_irq();
        go(PCSTK_OP_JUMP, 11'h123, 8'h00);
        go(PCSTK_OP_IRQ, 11'h000, 8'h00);
        `CHK("pc vec", IRQ_VECTOR, pc)
        go(PCSTK_OP_RET, 11'h000, 8'h00);
        `CHK("pc reti", 13'h0123, pc)
        @(negedge clk);
        rst_n = 1'b0;
        @(posedge clk);
        #1;
        `CHK("pc rerst", 13'h0000, pc)
        @(negedge clk);
        op = PCSTK_OP_HOLD;
        rst_n = 1'b1;
        go(PCSTK_OP_HOLD, 11'h000, 8'h00);
        `CHK("pc after rerst", 13'h0000, pc)
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_basic();
        t_wrlow();
        t_jump();
        t_stack();
        t_irq();
        report_and_stop();
    end
endmodule // pcstk_core_tb
`default_nettype wire
